/* wwd_consts.vh */
`ifndef WWD_CONSTS_VH
`define WWD_CONSTS_VH

// ----------------------------------------
// Clock and timing figures
// ----------------------------------------
`define WWD_CLK_PERIOD_NS 20
`define WWD_DEGLITCH_NS 5500
`define WWD_FLAG_CLR_NS 5000

// ----------------------------------------
// Window figures, in oscillator periods
// ----------------------------------------
`define WWD_WIN_TICKS 5000
`define WWD_FIRST_MULT 8
`define WWD_FAULT_TICKS 1

// ----------------------------------------
// Defaults for tunable counts
// ----------------------------------------
`define WWD_OSC_DIV 500
`define WWD_RST_DELAY_CYC 12500
`define WWD_CNT_W 16
`define WWD_POR_W 24
`define WWD_DIV_W 16

// ----------------------------------------
// Watchdog states
// ----------------------------------------
`define WWD_ST_IDLE 2'h0
`define WWD_ST_FIRST 2'h1
`define WWD_ST_CLOSED 2'h2
`define WWD_ST_OPEN 2'h3

`endif

/* wwd_sync.v */
`timescale 1ns/10ps

// Two-stage synchroniser for asynchronous pins
module wwd_sync #(
	parameter WIDTH = 1
) (
	input wire CLK_SYS,
	input wire RESET,
	input wire [WIDTH-1:0] d_in,
	output wire [WIDTH-1:0] d_out
);
	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;

	// First stage feeds only the second
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			s1_q <= {WIDTH{1'b0}};
			s2_q <= {WIDTH{1'b0}};
		end else begin
			s1_q <= d_in;
			s2_q <= s1_q;
		end
	end

	assign d_out = s2_q;
endmodule

/* wwd_top.v */
`timescale 1ns/10ps
`include "wwd_consts.vh"

module wwd_top #(
	parameter LATCH_VARIANT = 0,
	parameter OSC_DIV = `WWD_OSC_DIV,
	parameter WIN_TICKS = `WWD_WIN_TICKS,
	parameter RST_DELAY_CYC = `WWD_RST_DELAY_CYC
) (
	input wire CLK_SYS,
	input wire RESET,
	input wire GUARD_ENABLE_LOW,
	input wire SERVICE_PULSE,
	input wire VOUT_GOOD,
	output wire FAULT_PULSE_OUT,
	output wire FAULT_LATCH_OUT,
	output wire RESET_OUT_LOW
);
	// ----------------------------------------
	// Derived counts
	// ----------------------------------------
	localparam DEGLITCH_CYC = (`WWD_DEGLITCH_NS + `WWD_CLK_PERIOD_NS - 1) / `WWD_CLK_PERIOD_NS;
	localparam FLAG_CLR_CYC = `WWD_FLAG_CLR_NS / `WWD_CLK_PERIOD_NS;
	localparam [`WWD_CNT_W-1:0] HALF_LAST = WIN_TICKS / 2 - 1;
	localparam [`WWD_CNT_W-1:0] FIRST_LAST = WIN_TICKS * `WWD_FIRST_MULT - 1;
	localparam [`WWD_DIV_W-1:0] DIV_LAST = OSC_DIV - 1;
	localparam [`WWD_POR_W-1:0] POR_LAST = RST_DELAY_CYC - 1;
	localparam [`WWD_POR_W-1:0] DEG_LAST = DEGLITCH_CYC - 1;
	localparam [`WWD_POR_W-1:0] CLR_LAST = FLAG_CLR_CYC - 1;
	localparam [`WWD_DIV_W-1:0] FLT_TICKS = `WWD_FAULT_TICKS;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [2:0] pins_s;

	wwd_sync #(
		.WIDTH(3)
	) u_sync (
		.CLK_SYS(CLK_SYS),
		.RESET(RESET),
		.d_in({GUARD_ENABLE_LOW, SERVICE_PULSE, VOUT_GOOD}),
		.d_out(pins_s)
	);

	wire en_low_s = pins_s[2];
	wire svc_s = pins_s[1];
	wire vout_s = pins_s[0];

	// ----------------------------------------
	// Oscillator tick divider
	// ----------------------------------------
	reg [`WWD_DIV_W-1:0] div_q;
	reg tick_q;

	// One-cycle enable per oscillator period
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			div_q <= {`WWD_DIV_W{1'b0}};
			tick_q <= 1'b0;
		end else if (div_q == DIV_LAST) begin
			div_q <= {`WWD_DIV_W{1'b0}};
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Power-good reset generation
	// ----------------------------------------
	reg por_ok_q;
	reg [`WWD_POR_W-1:0] por_cnt_q;
	reg [`WWD_POR_W-1:0] low_cnt_q;

	// Delay on rise, deglitch on fall
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			por_ok_q <= 1'b0;
			por_cnt_q <= {`WWD_POR_W{1'b0}};
			low_cnt_q <= {`WWD_POR_W{1'b0}};
		end else if (vout_s) begin
			low_cnt_q <= {`WWD_POR_W{1'b0}};
			if (!por_ok_q) begin
				if (por_cnt_q == POR_LAST) begin
					por_ok_q <= 1'b1;
				end else begin
					por_cnt_q <= por_cnt_q + 1'b1;
				end
			end
		end else begin
			por_cnt_q <= {`WWD_POR_W{1'b0}};
			if (por_ok_q) begin
				if (low_cnt_q == DEG_LAST) begin
					por_ok_q <= 1'b0;
				end else begin
					low_cnt_q <= low_cnt_q + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Edge detection and service sampling
	// ----------------------------------------
	reg en_prev_q;
	reg rst_prev_q;
	reg por_prev_q;
	reg svc_smp_q;
	reg flt_act_q;
	reg flt_prev_q;
	reg reset_n_q;
	wire en_on;
	wire run;
	wire en_fall_pin;
	wire rst_rise;
	wire flt_end;
	wire svc_edge;
	wire por_drop;

	assign en_on = ~en_low_s;
	assign run = en_on & reset_n_q;
	assign en_fall_pin = en_on & ~en_prev_q;
	assign rst_rise = reset_n_q & ~rst_prev_q;
	assign flt_end = flt_prev_q & ~flt_act_q;
	assign svc_edge = tick_q & svc_s & ~svc_smp_q;
	assign por_drop = por_prev_q & ~por_ok_q;

	// Previous values and tick-rate service sample
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			en_prev_q <= 1'b1; // Idle level of a floating enable pin, no false edge
			rst_prev_q <= 1'b0;
			por_prev_q <= 1'b0;
			svc_smp_q <= 1'b0;
			flt_prev_q <= 1'b0;
		end else begin
			en_prev_q <= en_on;
			rst_prev_q <= reset_n_q;
			por_prev_q <= por_ok_q;
			flt_prev_q <= flt_act_q;
			if (tick_q) begin
				svc_smp_q <= svc_s;
			end
		end
	end

	// ----------------------------------------
	// Window state machine
	// ----------------------------------------
	reg [1:0] st_q;
	reg [1:0] st_d;
	reg [`WWD_CNT_W-1:0] cnt_q;
	reg [`WWD_CNT_W-1:0] cnt_d;
	reg fault_evt;
	reg good_svc;
	reg init_evt;

	// Initialization sources
	always @* begin
		init_evt = 1'b0;
		if (rst_rise && en_on) begin
			init_evt = 1'b1;
		end
		if (en_fall_pin && reset_n_q) begin
			init_evt = 1'b1;
		end
		if (LATCH_VARIANT == 0 && flt_end && run) begin
			init_evt = 1'b1;
		end
	end

	// Next state, fault and service decisions
	always @* begin
		st_d = st_q;
		cnt_d = cnt_q;
		fault_evt = 1'b0;
		good_svc = 1'b0;
		if (!run) begin
			st_d = `WWD_ST_IDLE;
			cnt_d = {`WWD_CNT_W{1'b0}};
		end else if (init_evt) begin
			st_d = `WWD_ST_FIRST;
			cnt_d = {`WWD_CNT_W{1'b0}};
		end else if (tick_q) begin
			case (st_q)
				`WWD_ST_FIRST: begin
					if (svc_edge) begin
						good_svc = 1'b1;
						st_d = `WWD_ST_CLOSED;
						cnt_d = {`WWD_CNT_W{1'b0}};
					end else if (cnt_q == FIRST_LAST) begin
						fault_evt = 1'b1;
						st_d = `WWD_ST_IDLE;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				`WWD_ST_CLOSED: begin
					if (svc_edge) begin
						fault_evt = 1'b1;
						st_d = `WWD_ST_IDLE;
					end else if (cnt_q == HALF_LAST) begin
						st_d = `WWD_ST_OPEN;
						cnt_d = {`WWD_CNT_W{1'b0}};
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				`WWD_ST_OPEN: begin
					if (svc_edge) begin
						good_svc = 1'b1;
						st_d = `WWD_ST_CLOSED;
						cnt_d = {`WWD_CNT_W{1'b0}};
					end else if (cnt_q == HALF_LAST) begin
						fault_evt = 1'b1;
						st_d = `WWD_ST_IDLE;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				default: begin
					st_d = `WWD_ST_IDLE;
					cnt_d = {`WWD_CNT_W{1'b0}};
				end
			endcase
		end
	end

	// State and counter registers
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			st_q <= `WWD_ST_IDLE;
			cnt_q <= {`WWD_CNT_W{1'b0}};
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// Fault pulse timer
	// ----------------------------------------
	reg [`WWD_DIV_W-1:0] flt_ticks_q;

	// Pulse starts on a tick, ends after one oscillator period
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			flt_act_q <= 1'b0;
			flt_ticks_q <= {`WWD_DIV_W{1'b0}};
		end else if (fault_evt) begin
			flt_act_q <= 1'b1;
			flt_ticks_q <= {`WWD_DIV_W{1'b0}};
		end else if (flt_act_q && tick_q) begin
			if (flt_ticks_q == FLT_TICKS - 1'b1) begin
				flt_act_q <= 1'b0;
			end else begin
				flt_ticks_q <= flt_ticks_q + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Latched flag with delayed service clear
	// ----------------------------------------
	reg flag_q;
	reg clr_pend_q;
	reg [`WWD_POR_W-1:0] clr_cnt_q;

	// Set wins over every clear source
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			flag_q <= 1'b0;
			clr_pend_q <= 1'b0;
			clr_cnt_q <= {`WWD_POR_W{1'b0}};
		end else if (LATCH_VARIANT != 0 && fault_evt) begin
			flag_q <= 1'b1;
			clr_pend_q <= 1'b0;
		end else if (por_drop || en_fall_pin) begin
			flag_q <= 1'b0;
			clr_pend_q <= 1'b0;
		end else if (good_svc && flag_q && !clr_pend_q) begin
			clr_pend_q <= 1'b1; // Later services do not postpone the clear
			clr_cnt_q <= {`WWD_POR_W{1'b0}};
		end else if (clr_pend_q) begin
			if (!run) begin
				clr_pend_q <= 1'b0;
			end else if (clr_cnt_q == CLR_LAST) begin
				flag_q <= 1'b0;
				clr_pend_q <= 1'b0;
			end else begin
				clr_cnt_q <= clr_cnt_q + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	reg fault_n_q;

	// Reset low while power bad or latch-variant fault pulse
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			reset_n_q <= 1'b0;
			fault_n_q <= 1'b1;
		end else begin
			reset_n_q <= por_ok_q & ~(LATCH_VARIANT != 0 && flt_act_q);
			fault_n_q <= ~(LATCH_VARIANT == 0 && flt_act_q);
		end
	end

	assign RESET_OUT_LOW = reset_n_q;
	assign FAULT_PULSE_OUT = fault_n_q;
	assign FAULT_LATCH_OUT = flag_q;
endmodule

/* wwd_top_properties.sv */
`timescale 1ns/10ps
// --------
// Port checker
// --------
module wwd_chk #(
	parameter LATCH_VARIANT = 0,
	parameter OSC_DIV = 500,
	parameter RST_DELAY_CYC = 12500
) (
	input wire CLK_SYS,
	input wire RESET,
	input wire GUARD_ENABLE_LOW,
	input wire VOUT_GOOD,
	input wire FAULT_PULSE_OUT,
	input wire FAULT_LATCH_OUT,
	input wire RESET_OUT_LOW
);
	int lo_q, rl_q, vh_q, vl_q, dq_q;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// Run lengths of pin levels
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			lo_q <= 0;
			rl_q <= 0;
			vh_q <= 0;
			vl_q <= 0;
			dq_q <= 0;
		end else begin
			lo_q <= FAULT_PULSE_OUT ? 0 : lo_q + 1;
			rl_q <= RESET_OUT_LOW ? 0 : rl_q + 1;
			vh_q <= VOUT_GOOD ? vh_q + 1 : 0;
			vl_q <= VOUT_GOOD ? 0 : vl_q + 1;
			dq_q <= GUARD_ENABLE_LOW ? dq_q + 1 : 0;
		end
	end
	// Flag rise and its reset pulse
	sequence flag_set;
		$rose(FAULT_LATCH_OUT);
	endsequence
	sequence rst_drop;
		##[0:1] !RESET_OUT_LOW;
	endsequence
	pulse_len_a: assert property ($rose(FAULT_PULSE_OUT) |-> lo_q == OSC_DIV)
		else $error("fault pulse length");
	flag_rst_a: assert property (flag_set |-> rst_drop)
		else $error("flag without reset pulse");
	rst_len_a: assert property ($rose(RESET_OUT_LOW) |-> rl_q == OSC_DIV || rl_q > RST_DELAY_CYC)
		else $error("reset pulse length");
	rst_delay_a: assert property ($rose(RESET_OUT_LOW) |-> vh_q >= RST_DELAY_CYC)
		else $error("reset rose early");
	por_drop_a: assert property (vl_q == 285 |-> !RESET_OUT_LOW)
		else $error("reset high after output loss");
	off_quiet_a: assert property (dq_q >= 8 |-> !$fell(FAULT_PULSE_OUT) && !$rose(FAULT_LATCH_OUT))
		else $error("fault while disabled");
	pulse_var_a: assert property (LATCH_VARIANT != 0 || !FAULT_LATCH_OUT)
		else $error("flag in pulse variant");
	latch_var_a: assert property (LATCH_VARIANT == 0 || FAULT_PULSE_OUT)
		else $error("pulse in latch variant");
endmodule

bind wwd_top wwd_chk #(.LATCH_VARIANT(LATCH_VARIANT), .OSC_DIV(OSC_DIV), .RST_DELAY_CYC(RST_DELAY_CYC)) u_chk (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .GUARD_ENABLE_LOW(GUARD_ENABLE_LOW), .VOUT_GOOD(VOUT_GOOD),
	.FAULT_PULSE_OUT(FAULT_PULSE_OUT), .FAULT_LATCH_OUT(FAULT_LATCH_OUT), .RESET_OUT_LOW(RESET_OUT_LOW));

/* wwd_mcu.sv */
`timescale 1ns/10ps
// --------
// Controller model
// --------
module wwd_mcu #(
	parameter OSC_DIV = 4
) (
	input wire clk,
	output logic svc = 0,
	output logic en_low = 0
);
	// Service pulse held three oscillator periods
	task automatic service();
		@(posedge clk) #1 svc = 1;
		repeat (3 * OSC_DIV) @(posedge clk);
		#1 svc = 0;
	endtask
	// Enable pin level
	task automatic enable(input logic v);
		@(posedge clk) #1 en_low = v;
	endtask
endmodule

/* wwd_top_tb_top.sv */
`timescale 1ns/10ps
// --------
// Bench
// --------
module wwd_top_tb_top;
	logic clk = 0;
	logic rst = 1;
	logic vgood = 0;
	logic fp_q = 1;
	logic ok;
	wire svc, en_low;
	wire [1:0] fp, fl, ro;
	int cyc = 0, nfault = 0, t_fall = 0, num_errors = 0, checked = 0, r, i, n0;
	// Short figures so that every window fits the run
	localparam int DIV = 4;
	localparam int WIN = 16;
	localparam int RDLY = 20;
	// Clock and blocks, pulse then latch variant
	always #10 clk = ~clk;
	wwd_mcu #(.OSC_DIV(DIV)) u_mcu (.clk(clk), .svc(svc), .en_low(en_low));
	for (genvar g = 0; g < 2; g++) begin : gv
		wwd_top #(.LATCH_VARIANT(g), .OSC_DIV(DIV), .WIN_TICKS(WIN), .RST_DELAY_CYC(RDLY)) u_dut (.CLK_SYS(clk),
			.RESET(rst), .GUARD_ENABLE_LOW(en_low), .SERVICE_PULSE(svc), .VOUT_GOOD(vgood),
			.FAULT_PULSE_OUT(fp[g]), .FAULT_LATCH_OUT(fl[g]), .RESET_OUT_LOW(ro[g]));
	end
	// Fault edge log and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		fp_q <= fp[0];
		if (fp_q === 1'b1 && fp[0] === 1'b0) begin
			nfault <= nfault + 1;
			t_fall <= cyc;
		end
		if (cyc == 8000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic s, input logic e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %b got %b", nm, e, s);
		end
	endtask
	task test_done();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Next fault, its delay from r within lo..hi
	task automatic wait_fault(input int lo, input int hi);
		int n;
		n = nfault;
		for (i = 0; i < 700 && nfault == n; i++) @(posedge clk);
		ok = t_fall - r >= lo && t_fall - r <= hi && nfault == n + 1;
	endtask
	task automatic t_power();
		repeat (5) @(posedge clk);
		#1 vgood = 1;
		r = cyc;
		for (i = 0; i < 60 && ro[0] !== 1'b1; i++) @(posedge clk);
		chk("rst_delay", cyc - r >= 20 && cyc - r <= 27, 1);
		r = cyc;
		wait_fault(504, 526);
		chk("first_win", ok, 1);
		repeat (2) @(posedge clk);
		chk("flag_set", fl[1], 1);
		chk("no_flag", fl[0], 0);
		$display("power end");
	endtask
	task automatic t_service();
		for (i = 0; i < 20 && fp[0] !== 1'b1; i++) @(posedge clk);
		repeat (50) @(posedge clk);
		n0 = nfault;
		u_mcu.service();
		repeat (6) begin
			repeat (35) @(posedge clk);
			u_mcu.service();
		end
		chk("no_fault", nfault == n0, 1);
		chk("flag_clr", fl[1], 0);
		r = cyc - 12;
		wait_fault(62, 80);
		chk("open_miss", ok, 1);
		$display("service end");
	endtask
	task automatic t_closed();
		for (i = 0; i < 20 && fp[0] !== 1'b1; i++) @(posedge clk);
		repeat (20) @(posedge clk);
		u_mcu.service();
		n0 = nfault;
		repeat (4) @(posedge clk);
		u_mcu.service();
		repeat (4) @(posedge clk);
		chk("closed_hit", nfault == n0 + 1, 1);
		chk("flag_set", fl[1], 1);
		$display("closed end");
	endtask
	task automatic t_disable();
		for (i = 0; i < 600 && fp[0] !== 1'b0; i++) @(posedge clk);
		u_mcu.enable(1);
		n0 = nfault;
		repeat (700) @(posedge clk);
		chk("off_quiet", nfault == n0, 1);
		chk("flag_hold", fl[1], 1);
		u_mcu.enable(0);
		r = cyc;
		repeat (8) @(posedge clk);
		chk("reen_clr", fl[1], 0);
		wait_fault(504, 526);
		chk("reen_init", ok, 1);
		$display("disable end");
	endtask
	task automatic t_por();
		// Let the watchdog reset pulse end before the output dips
		for (i = 0; i < 20 && fp[0] !== 1'b1; i++) @(posedge clk);
		repeat (10) @(posedge clk);
		#1 vgood = 0;
		repeat (100) @(posedge clk);
		#1 vgood = 1;
		repeat (10) @(posedge clk);
		chk("glitch", ro[0], 1);
		#1 vgood = 0;
		repeat (290) @(posedge clk);
		chk("por_low", ro[1], 0);
		chk("por_clr", fl[1], 0);
		#1 vgood = 1;
		for (i = 0; i < 60 && ro[0] !== 1'b1; i++) @(posedge clk);
		r = cyc;
		wait_fault(504, 526);
		chk("por_init", ok, 1);
		$display("por end");
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		#1 rst = 0;
		t_power();
		t_service();
		t_closed();
		t_disable();
		t_por();
		test_done();
	end
endmodule
